// ==== mx_move_exec.sv ====
// Execution unit for the move-class instructions of the core.
// Assumes memory answers a read by the last state of the instruction
// and holds the byte on mem_rdata_in until done_out.
`timescale 1ns/10ps
`include "mx_move_params.svh"

// Functional notes
// - Upper-word load puts 16-bit immediate in dword bits 31:16; 5B/3S bin, 4B/2S src.
// - Sign-extending copy byte to word; 2 states binary, 1 state source.
// - Zero-extending copy byte to word; 2 states binary, 1 state source.
// - Code read at data pointer plus accumulator into accumulator, 1 byte, 6 states.
// - Code read at program counter plus accumulator, 1 byte, 6 states.
// - Extended read via index register: 4 states binary, 5 source, 1 byte.
// - Extended read via data pointer: 3 base states, 1 byte.
// - Extended write via index register: 4 states both modes, 1 byte.
// - Extended write via data pointer: 4 base states, 1 byte.
// - Extended transfers use the region byte, which resets to 01h.
// - External code read or pointer write adds N+1 states.
// - External pointer extended read adds N+2 states.
// - Direct port access adds 1 state, peripheral register adds 2.
// - Direct-to-direct move pays the penalty per operand over 3 base states.
// - Direct byte to accumulator: 2 bytes, 1 base state.
// - Indirect load to accumulator: 2 states binary, 3 source.
// - Direct byte to bank register: 2B/1S binary, 3B/2S source.
// - Bank register to direct byte: 2 states binary, 3 source.
// - Direct-to-direct move is 3 bytes in both modes.
// - Accumulator to indirect address: 3 states binary, 4 source.
// - Data pointer load with constant: 3 bytes, 2 states.
module mx_move_exec
  import mx_move_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // Command
  input  wire logic        start_in,
  input  wire mx_op_t      op_in,
  input  wire logic        source_mode_in,
  output logic             busy_out,
  output logic             done_out,
  output logic [2:0]       bytes_out,
  output logic [4:0]       states_out,
  // Operands
  input  wire logic [7:0]  acc_in,
  input  wire logic [7:0]  bank_in,
  input  wire logic [7:0]  index_in,
  input  wire logic [31:0] dword_in,
  input  wire logic [15:0] data_pointer_in,
  input  wire logic [15:0] pc_in,
  input  wire logic [15:0] imm_in,
  input  wire logic [7:0]  dir_src_in,
  input  wire logic [7:0]  dir_dst_in,
  input  wire mx_dir_t     src_class_in,
  input  wire mx_dir_t     dst_class_in,
  input  wire logic        ext_in,
  input  wire logic [3:0]  wait_in,
  // Extended region byte
  input  wire logic        region_we_in,
  input  wire logic [7:0]  region_in,
  output logic [7:0]       region_out,
  // Results
  output logic [7:0]       acc_out,
  output logic [7:0]       bank_out,
  output logic [15:0]      word_out,
  output logic [31:0]      dword_out,
  output logic [15:0]      data_pointer_out,
  // Memory
  output logic             mem_rd_out,
  output logic             mem_wr_out,
  output mx_space_t        mem_space_out,
  output logic [23:0]      mem_addr_out,
  output logic [7:0]       mem_wdata_out,
  input  wire logic [7:0]  mem_rdata_in
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mx_state_t   state, next_state;
  mx_op_t      op_q, next_op_q;
  logic [7:0]  acc_q, bank_q, idx_q, dst_q;
  logic [7:0]  next_acc_q, next_bank_q, next_idx_q, next_dst_q;
  logic [31:0] dword_q, next_dword_q;
  logic [15:0] imm_q, next_imm_q;
  logic        next_busy, next_done, next_rd, next_wr;
  logic [2:0]  next_bytes;
  logic [4:0]  next_states;
  logic [7:0]  next_region, next_acc_out, next_bank_out, next_wdata;
  logic [15:0] next_word, next_data_pointer;
  logic [31:0] next_dword_out;
  mx_space_t   next_space;
  logic [23:0] next_addr;
  logic [2:0]  calc_bytes;
  logic [4:0]  calc_states;
  logic        accept, step_last;

  assign accept = start_in && (state == MX_IDLE);

  // ----------------------------------------------------------------
  // Timing and pacing
  // ----------------------------------------------------------------
  mx_timing u_timing (
    .op_in          (op_in),
    .source_mode_in (source_mode_in),
    .src_class_in   (src_class_in),
    .dst_class_in   (dst_class_in),
    .ext_in         (ext_in),
    .wait_in        (wait_in),
    .bytes_out      (calc_bytes),
    .states_out     (calc_states)
  );

  mx_step_counter u_steps (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .load_in  (accept),
    .value_in (calc_states),
    .count_in (state == MX_RUN),
    .last_out (step_last)
  );

  // ----------------------------------------------------------------
  // Next-value logic
  // ----------------------------------------------------------------
  // Sequencing, memory requests and results in one place so the
  // final state and the write strobe can never disagree
  always_comb begin
    next_state = state;     next_op_q = op_q;     next_acc_q = acc_q;
    next_bank_q = bank_q;   next_idx_q = idx_q;   next_dst_q = dst_q;
    next_dword_q = dword_q; next_imm_q = imm_q;
    next_bytes = bytes_out; next_states = states_out;
    next_region = region_out;
    next_acc_out = acc_out; next_bank_out = bank_out; next_word = word_out;
    next_dword_out = dword_out; next_data_pointer = data_pointer_out;
    next_space = mem_space_out; next_addr = mem_addr_out;
    next_wdata = mem_wdata_out;
    next_busy = busy_out;   next_done = 1'b0;
    next_rd = 1'b0;         next_wr = 1'b0;
    if (region_we_in) begin
      next_region = region_in;
    end
    case (state)
      MX_IDLE: begin
        if (accept) begin
          next_state = MX_RUN;  next_busy = 1'b1;
          next_op_q = op_in;    next_acc_q = acc_in;  next_bank_q = bank_in;
          next_idx_q = index_in; next_dst_q = dir_dst_in;
          next_dword_q = dword_in; next_imm_q = imm_in;
          next_bytes = calc_bytes; next_states = calc_states;
          // Read issued in the first state
          next_rd = 1'b1;
          case (op_in)
            MX_CODE_DP: begin
              next_space = MX_SP_CODE;
              next_addr = {`MX_HIGH_ZERO, 16'(data_pointer_in + {8'h00, acc_in})};
            end
            MX_CODE_PC: begin
              next_space = MX_SP_CODE;
              next_addr = {`MX_HIGH_ZERO, 16'(pc_in + {8'h00, acc_in})};
            end
            MX_XRD_IX: begin
              next_space = MX_SP_EXTENDED;
              next_addr = {region_out, `MX_HIGH_ZERO, index_in};
            end
            MX_XRD_DP: begin
              next_space = MX_SP_EXTENDED;
              next_addr = {region_out, data_pointer_in};
            end
            MX_A_DIR, MX_BANK_DIR, MX_DIR_DIR: begin
              next_space = MX_SP_INTERNAL;
              next_addr = {`MX_HIGH_ZERO, `MX_HIGH_ZERO, dir_src_in};
            end
            MX_A_IND: begin
              next_space = MX_SP_INTERNAL;
              next_addr = {`MX_HIGH_ZERO, `MX_HIGH_ZERO, index_in};
            end
            default: next_rd = 1'b0;
          endcase
        end
      end
      MX_RUN: begin
        if (step_last) begin
          next_state = MX_IDLE; next_busy = 1'b0; next_done = 1'b1;
          next_wr = 1'b1;
          case (op_q)
            MX_UWL:  next_dword_out = {imm_q, dword_q[15:0]};
            MX_SEXT: next_word = {{8{bank_q[7]}}, bank_q};
            MX_ZEXT: next_word = {`MX_HIGH_ZERO, bank_q};
            MX_CODE_DP, MX_CODE_PC, MX_XRD_IX, MX_XRD_DP, MX_A_DIR, MX_A_IND:
              next_acc_out = mem_rdata_in;
            MX_A_BANK: next_acc_out = bank_q;
            MX_A_IMM:  next_acc_out = imm_q[7:0];
            MX_BANK_DIR: next_bank_out = mem_rdata_in;
            MX_BANK_A:   next_bank_out = acc_q;
            MX_DP_LOAD:  next_data_pointer = imm_q;
            default: next_wr = 1'b0;
          endcase
          next_wr = 1'b0;
          case (op_q)
            MX_XWR_IX: begin
              next_wr = 1'b1; next_space = MX_SP_EXTENDED; next_wdata = acc_q;
              next_addr = {region_out, `MX_HIGH_ZERO, idx_q};
            end
            MX_XWR_DP: begin
              next_wr = 1'b1; next_space = MX_SP_EXTENDED; next_wdata = acc_q;
              next_addr = {region_out, data_pointer_out};
            end
            MX_DIR_A, MX_DIR_BANK: begin
              next_wr = 1'b1; next_space = MX_SP_INTERNAL;
              next_wdata = (op_q == MX_DIR_A) ? acc_q : bank_q;
              next_addr = {`MX_HIGH_ZERO, `MX_HIGH_ZERO, dst_q};
            end
            MX_DIR_DIR: begin
              next_wr = 1'b1; next_space = MX_SP_INTERNAL; next_wdata = mem_rdata_in;
              next_addr = {`MX_HIGH_ZERO, `MX_HIGH_ZERO, dst_q};
            end
            MX_IND_A: begin
              next_wr = 1'b1; next_space = MX_SP_INTERNAL; next_wdata = acc_q;
              next_addr = {`MX_HIGH_ZERO, `MX_HIGH_ZERO, idx_q};
            end
            default: next_wr = 1'b0;
          endcase
        end
      end
      default: next_state = MX_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Only the pointer write uses data_pointer_out, so a pointer load is seen
  // by the very next extended write
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state <= MX_IDLE;   op_q <= MX_UWL;    acc_q <= '0;   bank_q <= '0;
      idx_q <= '0;        dst_q <= '0;       dword_q <= '0; imm_q <= '0;
      busy_out <= 1'b0;   done_out <= 1'b0;  bytes_out <= '0; states_out <= '0;
      region_out <= `MX_REGION_RESET;        // region after reset
      acc_out <= '0;      bank_out <= '0;    word_out <= '0;
      dword_out <= '0;    data_pointer_out <= '0;
      mem_rd_out <= 1'b0; mem_wr_out <= 1'b0; mem_space_out <= MX_SP_INTERNAL;
      mem_addr_out <= '0; mem_wdata_out <= '0;
    end else begin
      state <= next_state; op_q <= next_op_q; acc_q <= next_acc_q;
      bank_q <= next_bank_q; idx_q <= next_idx_q; dst_q <= next_dst_q;
      dword_q <= next_dword_q; imm_q <= next_imm_q;
      busy_out <= next_busy; done_out <= next_done;
      bytes_out <= next_bytes; states_out <= next_states;
      region_out <= next_region;
      acc_out <= next_acc_out; bank_out <= next_bank_out; word_out <= next_word;
      dword_out <= next_dword_out; data_pointer_out <= next_data_pointer;
      mem_rd_out <= next_rd; mem_wr_out <= next_wr; mem_space_out <= next_space;
      mem_addr_out <= next_addr; mem_wdata_out <= next_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  // Busy cycles counted for the duration check
  logic [4:0] run_len;
  always_ff @(posedge mclk_in) begin
    if (rst_in || accept) begin
      run_len <= '0;
    end else if (busy_out) begin
      run_len <= 5'(run_len + `MX_ONE_STATE);
    end
  end

  upper_word_a: assert property (done_out && op_q == MX_UWL |->
      dword_out == {imm_q, dword_q[15:0]}) else $error("upper word load wrong");
  uwl_timing_a: assert property (accept && op_in == MX_UWL && !source_mode_in |=>
      states_out == 5'h03 && bytes_out == 3'h5) else $error("upper word timing wrong");
  sign_copy_a: assert property (done_out && op_q == MX_SEXT |->
      word_out == {{8{bank_q[7]}}, bank_q}) else $error("sign copy wrong");
  zero_copy_a: assert property (done_out && op_q == MX_ZEXT |->
      word_out[15:8] == 8'h00 && word_out[7:0] == bank_q) else $error("zero copy wrong");
  code_addr_a: assert property (accept && op_in == MX_CODE_DP |=>
      mem_rd_out && mem_addr_out[15:0] == 16'($past(data_pointer_in) + {8'h00, $past(acc_in)}))
      else $error("code read address wrong");
  ext_write_a: assert property (accept && op_in == MX_XWR_DP && ext_in |=>
      states_out == 5'(5'h05 + {1'b0, $past(wait_in)})) else $error("write wait wrong");
  ext_read_a: assert property (accept && op_in == MX_XRD_DP && ext_in |=>
      states_out == 5'(5'h05 + {1'b0, $past(wait_in)})) else $error("read wait wrong");
  dir_pair_a: assert property (accept && op_in == MX_DIR_DIR &&
      src_class_in == MX_DIR_PORT && dst_class_in == MX_DIR_PERIPH |=>
      states_out == 5'h06 && bytes_out == 3'h3) else $error("direct pair penalty wrong");
  bank_copy_a: assert property (accept && op_in == MX_A_BANK && source_mode_in |=>
      states_out == 5'h02 && bytes_out == 3'h2) else $error("bank copy timing wrong");
  run_length_a: assert property (done_out |-> run_len == states_out &&
      $past(busy_out) && !busy_out) else $error("state count not honoured");
  region_reset_a: assert property ($past(rst_in) && !region_we_in |->
      ##0 region_out == 8'h01 || $past(region_we_in)) else $error("region reset wrong");

  dir_dir_c: cover property (done_out && op_q == MX_DIR_DIR && mem_wr_out);
  ext_read_c: cover property (accept && op_in == MX_XRD_DP && ext_in ##[1:30] done_out);
  back_to_back_c: cover property (done_out ##1 busy_out);

endmodule

// ==== mx_move_params.svh ====
// Constants for the move-instruction execution unit.
// Assumes one clock where one execution state equals one clock cycle.
`ifndef MX_MOVE_PARAMS_SVH
`define MX_MOVE_PARAMS_SVH

// ----------------------------------------------------------------
// Reset values and state penalties
// ----------------------------------------------------------------
`define MX_REGION_RESET 8'h01
`define MX_PEN_NONE     5'h00
`define MX_PEN_PORT     5'h01
`define MX_PEN_PERIPH   5'h02
`define MX_PEN_EXT_SHORT 5'h01
`define MX_PEN_EXT_LONG  5'h02
`define MX_ONE_STATE    5'h01
`define MX_HIGH_ZERO    8'h00

// ----------------------------------------------------------------
// Timing words: binary bytes, binary states, source bytes, source states
// ----------------------------------------------------------------
`define MX_F_BIN_BYTES  15:13
`define MX_F_BIN_STATES 12:8
`define MX_F_SRC_BYTES  7:5
`define MX_F_SRC_STATES 4:0
`define MX_T_UWL      {3'h5, 5'h03, 3'h4, 5'h02}
`define MX_T_SEXT     {3'h3, 5'h02, 3'h2, 5'h01}
`define MX_T_ZEXT     {3'h3, 5'h02, 3'h2, 5'h01}
`define MX_T_CODE     {3'h1, 5'h06, 3'h1, 5'h06}
`define MX_T_XRD_IX   {3'h1, 5'h04, 3'h1, 5'h05}
`define MX_T_XRD_DP   {3'h1, 5'h03, 3'h1, 5'h03}
`define MX_T_XWR      {3'h1, 5'h04, 3'h1, 5'h04}
`define MX_T_A_BANK   {3'h1, 5'h01, 3'h2, 5'h02}
`define MX_T_A_DIR    {3'h2, 5'h01, 3'h2, 5'h01}
`define MX_T_A_IND    {3'h1, 5'h02, 3'h2, 5'h03}
`define MX_T_A_IMM    {3'h2, 5'h01, 3'h2, 5'h01}
`define MX_T_BANK_A   {3'h1, 5'h01, 3'h2, 5'h02}
`define MX_T_BANK_DIR {3'h2, 5'h01, 3'h3, 5'h02}
`define MX_T_DIR_A    {3'h2, 5'h02, 3'h2, 5'h02}
`define MX_T_DIR_BANK {3'h2, 5'h02, 3'h3, 5'h03}
`define MX_T_DIR_DIR  {3'h3, 5'h03, 3'h3, 5'h03}
`define MX_T_IND_A    {3'h1, 5'h03, 3'h2, 5'h04}
`define MX_T_DP_LOAD  {3'h3, 5'h02, 3'h3, 5'h02}

`endif

// ==== mx_move_pkg.sv ====
// Types shared by the move-instruction execution unit.
// Assumes the decoder upstream has already classified each instruction.
package mx_move_pkg;

  // ----------------------------------------------------------------
  // Operation, direct-address class, memory space, control state
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    MX_UWL, MX_SEXT, MX_ZEXT, MX_CODE_DP, MX_CODE_PC,
    MX_XRD_IX, MX_XRD_DP, MX_XWR_IX, MX_XWR_DP,
    MX_A_BANK, MX_A_DIR, MX_A_IND, MX_A_IMM, MX_BANK_A, MX_BANK_DIR,
    MX_DIR_A, MX_DIR_BANK, MX_DIR_DIR, MX_IND_A, MX_DP_LOAD
  } mx_op_t;

  typedef enum logic [1:0] {MX_DIR_RAM, MX_DIR_PORT, MX_DIR_PERIPH} mx_dir_t;

  typedef enum logic [1:0] {MX_SP_INTERNAL, MX_SP_CODE, MX_SP_EXTENDED} mx_space_t;

  typedef enum logic {MX_IDLE, MX_RUN} mx_state_t;

endpackage

// ==== mx_timing.sv ====
// Byte and state count of one move instruction.
// Assumes operand classes and the external flag are settled with the op.
`timescale 1ns/10ps
`include "mx_move_params.svh"

module mx_timing
  import mx_move_pkg::*;
(
  // Instruction
  input  wire mx_op_t     op_in,
  input  wire logic       source_mode_in,
  // Penalty sources
  input  wire mx_dir_t    src_class_in,
  input  wire mx_dir_t    dst_class_in,
  input  wire logic       ext_in,
  input  wire logic [3:0] wait_in,
  // Result
  output logic      [2:0] bytes_out,
  output logic      [4:0] states_out
);

  // Direct-address class penalty
  function automatic logic [4:0] dir_pen(input mx_dir_t cls);
    case (cls)
      MX_DIR_PORT:   dir_pen = `MX_PEN_PORT;
      MX_DIR_PERIPH: dir_pen = `MX_PEN_PERIPH;
      default:       dir_pen = `MX_PEN_NONE;
    endcase
  endfunction

  // Base table lookup plus penalties
  always_comb begin
    logic [15:0] tw;
    logic [4:0]  extra;
    tw    = `MX_T_UWL;
    extra = `MX_PEN_NONE;
    case (op_in)
      MX_UWL:      tw = `MX_T_UWL;      // upper word timing
      MX_SEXT:     tw = `MX_T_SEXT;     // sign copy timing
      MX_ZEXT:     tw = `MX_T_ZEXT;     // zero copy timing
      MX_CODE_DP:  tw = `MX_T_CODE;     // code read timing
      MX_CODE_PC:  tw = `MX_T_CODE;     // code read timing
      MX_XRD_IX:   tw = `MX_T_XRD_IX;   // short read timing
      MX_XRD_DP:   tw = `MX_T_XRD_DP;   // long read timing
      MX_XWR_IX:   tw = `MX_T_XWR;      // short write timing
      MX_XWR_DP:   tw = `MX_T_XWR;      // long write timing
      MX_A_BANK:   tw = `MX_T_A_BANK;   // bank copy timing
      MX_A_DIR:    tw = `MX_T_A_DIR;    // direct load timing
      MX_A_IND:    tw = `MX_T_A_IND;    // indirect load timing
      MX_A_IMM:    tw = `MX_T_A_IMM;
      MX_BANK_A:   tw = `MX_T_BANK_A;
      MX_BANK_DIR: tw = `MX_T_BANK_DIR; // bank load timing
      MX_DIR_A:    tw = `MX_T_DIR_A;
      MX_DIR_BANK: tw = `MX_T_DIR_BANK; // bank store timing
      MX_DIR_DIR:  tw = `MX_T_DIR_DIR;  // three byte encoding
      MX_IND_A:    tw = `MX_T_IND_A;    // indirect store timing
      MX_DP_LOAD:  tw = `MX_T_DP_LOAD;  // pointer load timing
      default:     tw = `MX_T_UWL;
    endcase
    case (op_in)
      MX_A_DIR, MX_BANK_DIR: extra = dir_pen(src_class_in);
      MX_DIR_A, MX_DIR_BANK: extra = dir_pen(dst_class_in);
      MX_DIR_DIR:            extra = 5'(dir_pen(src_class_in) + dir_pen(dst_class_in));
      default:               extra = `MX_PEN_NONE;
    endcase
    if (ext_in) begin
      case (op_in)
        MX_CODE_DP, MX_CODE_PC, MX_XWR_DP: extra = 5'({1'b0, wait_in} + `MX_PEN_EXT_SHORT);
        MX_XRD_DP:                         extra = 5'({1'b0, wait_in} + `MX_PEN_EXT_LONG);
        default:                           extra = extra;
      endcase
    end
    bytes_out  = source_mode_in ? tw[`MX_F_SRC_BYTES] : tw[`MX_F_BIN_BYTES];
    states_out = 5'((source_mode_in ? tw[`MX_F_SRC_STATES] : tw[`MX_F_BIN_STATES]) + extra);
  end

endmodule

// ==== mx_step_counter.sv ====
// Down counter that paces the states of one instruction.
// Assumes load and count requests never coincide.
`timescale 1ns/10ps
`include "mx_move_params.svh"

module mx_step_counter (
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  // Control
  input  wire logic       load_in,
  input  wire logic [4:0] value_in,
  input  wire logic       count_in,
  // Status
  output logic            last_out
);

  logic [4:0] count;
  logic [4:0] next_count;

  // Remaining states after the present one
  always_comb begin
    next_count = count;
    if (load_in) begin
      next_count = 5'(value_in - `MX_ONE_STATE);
    end else if (count_in && count != '0) begin
      next_count = 5'(count - `MX_ONE_STATE);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign last_out = (count == '0);

endmodule

// ==== mx_mem_model.sv ====
// Byte memory standing behind the move unit's memory port.
// Assumes one read pulse per instruction and no stall line.
`timescale 1ns/10ps

module mx_mem_model (
  // Clock and strobes
  input  wire logic        mclk_in,
  input  wire logic        rd_in,
  input  wire logic        done_in,
  // Address and data
  input  wire logic [23:0] addr_in,
  output logic      [7:0]  rdata_out
);
  logic [7:0] held = 8'h3C;

  // Answer within the pulse cycle; the content is a hash of the address
  assign rdata_out = rd_in ? (addr_in[7:0] ^ addr_in[23:16] ^ 8'hA5) : held;

  // Hold until done, then invert so a late sample sees stale garbage
  always @(posedge mclk_in) begin
    if (rd_in) begin
      held <= addr_in[7:0] ^ addr_in[23:16] ^ 8'hA5;
    end else if (done_in) begin
      held <= ~held;
    end
  end
endmodule

// ==== move_instruction_execution_tb.sv ====
// Self-checking bench for the move execution unit.
// Assumes the memory model answers reads in the strobe cycle.
`timescale 1ns/10ps

module move_instruction_execution_tb;
  import mx_move_pkg::*;
  logic        mclk_in = 0, rst_in = 1, start_in = 0, source_mode_in = 0, ext_in = 0, region_we_in = 0;
  mx_op_t      op_in = MX_UWL;
  mx_dir_t     src_class_in = MX_DIR_RAM, dst_class_in = MX_DIR_RAM;
  logic [7:0]  acc_in = 8'h10, bank_in = 8'h9C, index_in = 8'h44, dir_src_in = 8'h81, dir_dst_in = 8'h90;
  logic [7:0]  region_in = 8'h3C, mem_rdata_in, region_out, acc_out, bank_out, mem_wdata_out;
  logic [15:0] data_pointer_in = 16'h2000, pc_in = 16'h0100, imm_in = 16'hBEEF, word_out, data_pointer_out;
  logic [31:0] dword_in = 32'h12345678, dword_out;
  logic [3:0]  wait_in = 4'h0;
  logic        busy_out, done_out, mem_rd_out, mem_wr_out;
  logic [2:0]  bytes_out;
  logic [4:0]  states_out;
  logic [23:0] mem_addr_out;
  mx_space_t   mem_space_out;
  int          num_errors = 0, checks_done = 0, rd_seen = 0;
  // Bytes and states per op: binary bytes, binary states, source bytes, source states
  logic [15:0] tbl [20] = '{16'h5342, 16'h3221, 16'h3221, 16'h1616, 16'h1616, 16'h1415, 16'h1313,
    16'h1414, 16'h1414, 16'h1122, 16'h2121, 16'h1223, 16'h2121, 16'h1122, 16'h2132, 16'h2222,
    16'h2233, 16'h3333, 16'h1324, 16'h3232};

  mx_move_exec DUT (.mclk_in, .rst_in, .start_in, .op_in, .source_mode_in, .busy_out, .done_out,
    .bytes_out, .states_out, .acc_in, .bank_in, .index_in, .dword_in, .data_pointer_in, .pc_in, .imm_in,
    .dir_src_in, .dir_dst_in, .src_class_in, .dst_class_in, .ext_in, .wait_in, .region_we_in,
    .region_in, .region_out, .acc_out, .bank_out, .word_out, .dword_out, .data_pointer_out, .mem_rd_out,
    .mem_wr_out, .mem_space_out, .mem_addr_out, .mem_wdata_out, .mem_rdata_in);
  mx_mem_model MEM (.mclk_in, .rd_in(mem_rd_out), .done_in(done_out), .addr_in(mem_addr_out),
    .rdata_out(mem_rdata_in));

  // Clock at 125 MHz
  always #4 mclk_in = ~mclk_in;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Issue one op and stop in its done cycle; busy must last exactly the states
  task automatic run(input mx_op_t op, input logic mode, input int st, input int by);
    int k, n;
    n = 0;
    rd_seen = 0;
    op_in = op;
    source_mode_in = mode;
    start_in = 1'b1;
    @(posedge mclk_in);
    #1 start_in = 1'b0;
    for (k = 0; k < 40 && done_out !== 1'b1; k++) begin
      if (busy_out === 1'b1) n++;
      if (mem_rd_out === 1'b1) rd_seen++;
      @(posedge mclk_in);
      #1;
    end
    if (k == 40) begin
      chk("done timeout", 1, 0);
      test_done();
    end
    chk("states", st, states_out);
    chk("bytes", by, bytes_out);
    chk("busy cycles", st, n);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_table();
    for (int i = 0; i < 40; i++)
      run(mx_op_t'(i / 2), i[0], i[0] ? tbl[i/2][3:0] : tbl[i/2][11:8], i[0] ? tbl[i/2][7:4] : tbl[i/2][15:12]);
    $display("timing table done");
  endtask

  task automatic t_data();
    run(MX_UWL, 1'b0, 3, 5);
    chk("dword", 32'hBEEF5678, dword_out);
    run(MX_SEXT, 1'b1, 1, 2);
    chk("sign word", 16'hFF9C, word_out);
    run(MX_ZEXT, 1'b0, 2, 3);
    chk("zero word", 16'h009C, word_out);
    run(MX_BANK_DIR, 1'b0, 1, 2);
    chk("bank byte", 8'h24, bank_out);
    run(MX_DP_LOAD, 1'b1, 2, 3);
    chk("pointer", 16'hBEEF, data_pointer_out);
    $display("data results done");
  endtask

  task automatic t_penalty();
    src_class_in = MX_DIR_PORT;
    run(MX_A_DIR, 1'b0, 2, 2);
    src_class_in = MX_DIR_PERIPH;
    run(MX_A_DIR, 1'b1, 3, 2);
    src_class_in = MX_DIR_PORT;
    dst_class_in = MX_DIR_PERIPH;
    run(MX_DIR_DIR, 1'b0, 6, 3);
    chk("write strobe", 1, mem_wr_out);
    chk("write addr", 24'h000090, mem_addr_out);
    chk("write data", 8'h24, mem_wdata_out);
    src_class_in = MX_DIR_RAM;
    dst_class_in = MX_DIR_RAM;
    $display("port penalty done");
  endtask

  task automatic t_external();
    ext_in = 1'b1;
    wait_in = 4'h3;
    run(MX_CODE_DP, 1'b0, 10, 1);
    chk("code addr", 24'h002010, mem_addr_out);
    chk("code byte", 8'hB5, acc_out);
    chk("code space", MX_SP_CODE, mem_space_out);
    chk("read pulses", 1, rd_seen);
    wait_in = 4'h2;
    run(MX_XRD_DP, 1'b1, 7, 1);
    wait_in = 4'h0;
    run(MX_XWR_DP, 1'b0, 5, 1);
    chk("ptr write addr", 24'h01BEEF, mem_addr_out);
    ext_in = 1'b0;
    $display("external waits done");
  endtask

  task automatic t_region();
    chk("region reset", 8'h01, region_out);
    region_we_in = 1'b1;
    @(posedge mclk_in);
    #1 region_we_in = 1'b0;
    acc_in = 8'h5A;
    run(MX_XWR_IX, 1'b1, 4, 1);
    chk("ext addr", 24'h3C0044, mem_addr_out);
    chk("ext data", 8'h5A, mem_wdata_out);
    chk("ext space", MX_SP_EXTENDED, mem_space_out);
    chk("read pulses", 0, rd_seen);
    // Later code reads expect the original accumulator operand
    acc_in = 8'h10;
    // Reset between instructions, with the unit idle, must bring the region byte back
    rst_in = 1'b1;
    @(posedge mclk_in);
    #1 rst_in = 1'b0;
    chk("region after reset", 8'h01, region_out);
    $display("region transfer done");
  endtask

  // Reset for six cycles, then the scenarios in order
  initial begin
    repeat (6) @(posedge mclk_in);
    #1 rst_in = 1'b0;
    t_region();
    t_table();
    t_data();
    t_penalty();
    t_external();
    test_done();
  end
endmodule
